// ==== verilog/txl_top.sv ====
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Control single-space bit selects single or multiple space compare mode.
// - Eight-bit current process tag lives in page entry high; no purge needed.
// - Unified buffer has 64 associative entries for data and refill.
// - Compare upper 22, 20, 16 or 12 virtual bits by page size.
// - Tag compared unless shared; skipped in single mode when privileged.
// - Size code 00/01/10/11 means 1K/4K/64K/1M pages.
// - Valid flags cleared by power-on reset, kept over manual reset.
// - Physical address takes page bits 28 down to page boundary.
// - Protection key gates privileged/user read and write.
// - Each unified entry carries a dirty flag.
// - Write-through flag: 0 copy-back, 1 write-through.
// - Space attribute passed to bus unit for PCMCIA areas.
// - Timing select chooses area 5 or area 6 settings.
// - Instruction buffer has 4 associative entries.
// - Instruction entries drop dirty and write-through, keep upper protection bit.
// - Cache behaviour comes from hit entry attributes.
// - Untranslatable accesses raise an exception instead of completing.
// - Instruction miss searches unified buffer and refills slot from replace state.
// - Load command copies staging registers into unified entry at counter.
// - Instruction entries written via array port or by refill; both deletable.
// - Unified miss during instruction refill raises instruction miss exception.
module txl_top
   import txl_pkg::*;
#(
   parameter int UENTRIES = 64,
   parameter int IENTRIES = 4
)(
   // Clock and reset.
   input  wire logic        CLK_I,
   input  wire logic        RST_N_I,
   input  wire logic        PWR_ON_I,
   // Register port.
   input  wire logic [7:0]  REG_ADDR_I,
   input  wire logic [31:0] REG_WDATA_I,
   input  wire logic        REG_WR_I,
   input  wire logic        REG_RD_I,
   output logic      [31:0] REG_RDATA_O,
   // Access request from the core.
   input  wire logic        REQ_VALID_I,
   input  wire logic        REQ_INSTR_I,
   input  wire logic        REQ_WRITE_I,
   input  wire logic        REQ_USER_I,
   input  wire logic [31:0] REQ_VADDR_I,
   // Translation answer.
   output logic             RSP_VALID_O,
   output logic      [28:0] RSP_PADDR_O,
   output logic             RSP_CACHE_O,
   output logic             RSP_WTHRU_O,
   output logic      [2:0]  RSP_SPACE_O,
   output logic             RSP_TSEL_O,
   output logic      [2:0]  RSP_EXC_O,
   output logic             BUSY_O
);

   localparam int UW = $clog2(UENTRIES);
   localparam int IW = $clog2(IENTRIES);

   // The field widths and the refill pointer are sized for these counts only.
   if (UENTRIES != 64 || IENTRIES != 4)
   begin : g_bad_size
      $error("Entry counts must be 64 and 4.");
   end

   // Reset release through two flops.
   logic rst_s1_q;
   logic rst_n;
   always_ff @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         rst_s1_q <= 1'b0;
         rst_n    <= 1'b0;
      end
      else
      begin
         rst_s1_q <= 1'b1;
         rst_n    <= rst_s1_q;
      end
   end

   // Software-visible registers.
   logic          sv_q;
   logic [IW-1:0] instr_replace_state_q;
   logic [UW-1:0] urc_q;
   logic [31:0]   page_entry_high_reg_q;
   logic [31:0]   page_entry_low_reg_q;
   logic [3:0]    page_entry_assist_reg_q;
   logic [7:0]    iaddr_q;
   logic [2:0]    exc_q;

   // Unified entries.
   logic [21:0] u_vpn [UENTRIES];
   logic [7:0]  u_tag [UENTRIES];
   logic [18:0] u_ppn [UENTRIES];
   logic [1:0]  u_sz  [UENTRIES];
   logic [1:0]  u_pr  [UENTRIES];
   logic [3:0]  u_ea  [UENTRIES];
   logic [UENTRIES-1:0] u_v_q, u_sh_q, u_c_q, u_d_q, u_wt_q;

   // Instruction entries.
   logic [21:0] i_vpn [IENTRIES];
   logic [7:0]  i_tag [IENTRIES];
   logic [18:0] i_ppn [IENTRIES];
   logic [1:0]  i_sz  [IENTRIES];
   logic [3:0]  i_ea  [IENTRIES];
   logic [IENTRIES-1:0] i_v_q, i_sh_q, i_c_q, i_pr_q;

   wire [7:0]  cur_tag = page_entry_high_reg_q[7:0];
   wire [21:0] virtual_page_number     = REQ_VADDR_I[31:10];
   // Single mode skips the tag compare for privileged accesses only.
   wire tag_chk = !sv_q || REQ_USER_I;

   function automatic logic [21:0] sz_mask(input logic [1:0] sz);
      case (sz)
         SZ_1K:   sz_mask = 22'h3FFFFF;
         SZ_4K:   sz_mask = 22'h3FFFFC;
         SZ_64K:  sz_mask = 22'h3FFFC0;
         default: sz_mask = 22'h3FFC00;
      endcase
   endfunction : sz_mask

   logic [UENTRIES-1:0] u_hit;
   logic [IENTRIES-1:0] i_hit;
   genvar g;
   generate
      for (g = 0; g < UENTRIES; g++)
      begin : g_uhit
         assign u_hit[g] = u_v_q[g] && ((u_vpn[g] ^ virtual_page_number) & sz_mask(u_sz[g])) == 22'h0
                           && (u_sh_q[g] || !tag_chk || u_tag[g] == cur_tag);
      end
      for (g = 0; g < IENTRIES; g++)
      begin : g_ihit
         assign i_hit[g] = i_v_q[g] && ((i_vpn[g] ^ virtual_page_number) & sz_mask(i_sz[g])) == 22'h0
                           && (i_sh_q[g] || !tag_chk || i_tag[g] == cur_tag);
      end
   endgenerate

   logic [UW-1:0] u_idx;
   logic [IW-1:0] i_idx;
   always_comb
   begin
      u_idx = '0;
      i_idx = '0;
      for (int k = 0; k < UENTRIES; k++) if (u_hit[k]) u_idx = UW'(k);
      for (int k = 0; k < IENTRIES; k++) if (i_hit[k]) i_idx = IW'(k);
   end
   wire u_any  = |u_hit;
   wire u_mult = (u_hit & (u_hit - 1'b1)) != '0;
   wire i_any  = |i_hit;
   wire i_mult = (i_hit & (i_hit - 1'b1)) != '0;

   // Physical address: page bits from the entry, offset from the virtual address.
   function automatic logic [28:0] pa(input logic [18:0] physical_page_number, input logic [1:0] sz, input logic [31:0] va);
      logic [28:0] m;
      m  = {7'h00, sz_mask(sz)} << 10;
      pa = ({physical_page_number, 10'h000} & m) | (va[28:0] & ~m);
   endfunction : pa

   // Data protection check against the two-bit key.
   wire [1:0] dpr     = u_pr[u_idx];
   wire d_prot_bad = (REQ_USER_I && !dpr[1]) || (REQ_WRITE_I && !dpr[0]);
   wire i_prot_bad = REQ_USER_I && !i_pr_q[i_idx];
   // A write to a clean page is refused so software can mark it dirty.
   wire d_first_wr = REQ_WRITE_I && !u_d_q[u_idx];

   txl_state_t st_q, st_d;
   always_comb
   begin
      st_d = st_q;
      case (st_q)
         ST_IDLE:   if (REQ_VALID_I && REQ_INSTR_I && !i_any) st_d = ST_REFILL;
         ST_REFILL: st_d = ST_DONE;
         default:   st_d = ST_IDLE;
      endcase
   end
   // The refill answer is given by a retried lookup, keeping the hit path short.
   wire refill_now = st_q == ST_REFILL && u_any && !u_mult;

   // Register write decode.
   wire wr_ctrl = REG_WR_I && REG_ADDR_I == OFS_CTRL;
   wire wr_page_entry_high_reg = REG_WR_I && REG_ADDR_I == OFS_PAGE_ENTRY_HIGH_REG;
   wire wr_page_entry_low_reg = REG_WR_I && REG_ADDR_I == OFS_PAGE_ENTRY_LOW_REG;
   wire wr_page_entry_assist_reg = REG_WR_I && REG_ADDR_I == OFS_PAGE_ENTRY_ASSIST_REG;
   wire wr_cmd  = REG_WR_I && REG_ADDR_I == OFS_CMD;
   wire wr_iadr = REG_WR_I && REG_ADDR_I == OFS_IADDR;
   wire do_load = wr_cmd && REG_WDATA_I[CMD_LOAD];
   wire do_iwr  = wr_cmd && REG_WDATA_I[CMD_IWR];
   wire do_idel = wr_cmd && REG_WDATA_I[CMD_IDEL];
   wire do_udel = wr_cmd && REG_WDATA_I[CMD_UDEL];
   wire [UW-1:0] uix = iaddr_q[UW-1:0];
   wire [IW-1:0] iix = iaddr_q[IW-1:0];

   always_ff @(posedge CLK_I or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sv_q    <= 1'b0;
         instr_replace_state_q  <= '0;
         urc_q   <= '0;
         page_entry_high_reg_q  <= '0;
         page_entry_low_reg_q  <= '0;
         page_entry_assist_reg_q  <= '0;
         iaddr_q <= '0;
         st_q    <= ST_IDLE;
      end
      else
      begin
         st_q <= st_d;
         if (wr_ctrl)
         begin
            sv_q   <= REG_WDATA_I[CTRL_SV_BIT];
            instr_replace_state_q <= REG_WDATA_I[CTRL_INSTR_REPLACE_STATE_LSB +: IW];
            urc_q  <= REG_WDATA_I[CTRL_URC_LSB +: UW];
         end
         else if (refill_now) instr_replace_state_q <= instr_replace_state_q + 1'b1;
         if (wr_page_entry_high_reg) page_entry_high_reg_q <= REG_WDATA_I;
         if (wr_page_entry_low_reg) page_entry_low_reg_q <= REG_WDATA_I;
         if (wr_page_entry_assist_reg) page_entry_assist_reg_q <= REG_WDATA_I[3:0];
         if (wr_iadr) iaddr_q <= REG_WDATA_I[7:0];
      end
   end

   // Entry storage; valid flags follow the power-on flag only.
   always_ff @(posedge CLK_I)
   begin
      if (!rst_n && PWR_ON_I)
      begin
         u_v_q <= '0;
         i_v_q <= '0;
      end
      else
      begin
         if (do_load)
         begin
            u_vpn[urc_q]  <= page_entry_high_reg_q[31:10];
            u_tag[urc_q]  <= page_entry_high_reg_q[7:0];
            u_ppn[urc_q]  <= page_entry_low_reg_q[28:10];
            u_sz[urc_q]   <= {page_entry_low_reg_q[PAGE_ENTRY_LOW_REG_SZ1], page_entry_low_reg_q[PAGE_ENTRY_LOW_REG_SZ0]};
            u_pr[urc_q]   <= page_entry_low_reg_q[PAGE_ENTRY_LOW_REG_PR +: 2];
            u_ea[urc_q]   <= page_entry_assist_reg_q;
            u_v_q[urc_q]  <= page_entry_low_reg_q[PAGE_ENTRY_LOW_REG_V];
            u_sh_q[urc_q] <= page_entry_low_reg_q[PAGE_ENTRY_LOW_REG_SH];
            u_c_q[urc_q]  <= page_entry_low_reg_q[PAGE_ENTRY_LOW_REG_C];
            u_d_q[urc_q]  <= page_entry_low_reg_q[PAGE_ENTRY_LOW_REG_D];
            u_wt_q[urc_q] <= page_entry_low_reg_q[PAGE_ENTRY_LOW_REG_WT];
         end
         else if (do_udel) u_v_q[uix] <= 1'b0;
         if (refill_now)
         begin
            i_vpn[instr_replace_state_q]  <= u_vpn[u_idx];
            i_tag[instr_replace_state_q]  <= u_tag[u_idx];
            i_ppn[instr_replace_state_q]  <= u_ppn[u_idx];
            i_sz[instr_replace_state_q]   <= u_sz[u_idx];
            i_ea[instr_replace_state_q]   <= u_ea[u_idx];
            i_v_q[instr_replace_state_q]  <= 1'b1;
            i_sh_q[instr_replace_state_q] <= u_sh_q[u_idx];
            i_c_q[instr_replace_state_q]  <= u_c_q[u_idx];
            i_pr_q[instr_replace_state_q] <= u_pr[u_idx][1];
         end
         else if (do_iwr)
         begin
            i_vpn[iix]  <= page_entry_high_reg_q[31:10];
            i_tag[iix]  <= page_entry_high_reg_q[7:0];
            i_ppn[iix]  <= page_entry_low_reg_q[28:10];
            i_sz[iix]   <= {page_entry_low_reg_q[PAGE_ENTRY_LOW_REG_SZ1], page_entry_low_reg_q[PAGE_ENTRY_LOW_REG_SZ0]};
            i_ea[iix]   <= page_entry_assist_reg_q;
            i_v_q[iix]  <= page_entry_low_reg_q[PAGE_ENTRY_LOW_REG_V];
            i_sh_q[iix] <= page_entry_low_reg_q[PAGE_ENTRY_LOW_REG_SH];
            i_c_q[iix]  <= page_entry_low_reg_q[PAGE_ENTRY_LOW_REG_C];
            i_pr_q[iix] <= page_entry_low_reg_q[PAGE_ENTRY_LOW_REG_PR + 1];
         end
         else if (do_idel) i_v_q[iix] <= 1'b0;
      end
   end

   // Answer logic, registered one cycle after the request.
   logic [2:0] exc_d;
   always_comb
   begin
      exc_d = EXC_NONE;
      if (st_q == ST_REFILL)
         exc_d = u_mult ? EXC_DMULT : (!u_any ? EXC_IMISS : EXC_NONE);
      else if (REQ_INSTR_I)
         exc_d = i_mult ? EXC_IMULT : (i_prot_bad ? EXC_IPROT : EXC_NONE);
      else if (!u_any)
         exc_d = EXC_DMISS;
      else if (u_mult)
         exc_d = EXC_DMULT;
      else if (d_prot_bad)
         exc_d = EXC_DPROT;
      else if (d_first_wr)
         exc_d = EXC_WRITE;
   end
   wire ans = (REQ_VALID_I && st_q == ST_IDLE && (!REQ_INSTR_I || i_any)) || st_q == ST_REFILL;

   always_ff @(posedge CLK_I or negedge rst_n)
   begin
      if (!rst_n)
      begin
         RSP_VALID_O <= 1'b0;
         RSP_PADDR_O <= '0;
         RSP_CACHE_O <= 1'b0;
         RSP_WTHRU_O <= 1'b0;
         RSP_SPACE_O <= '0;
         RSP_TSEL_O  <= 1'b0;
         RSP_EXC_O   <= EXC_NONE;
         exc_q       <= EXC_NONE;
         REG_RDATA_O <= '0;
      end
      else
      begin
         RSP_VALID_O <= ans && !(st_q == ST_REFILL && exc_d == EXC_NONE);
         RSP_EXC_O   <= ans ? exc_d : EXC_NONE;
         if (ans && exc_d != EXC_NONE) exc_q <= exc_d;
         if (REQ_INSTR_I)
         begin
            RSP_PADDR_O <= pa(i_ppn[i_idx], i_sz[i_idx], REQ_VADDR_I);
            RSP_CACHE_O <= i_c_q[i_idx];
            RSP_WTHRU_O <= 1'b0;
            RSP_SPACE_O <= i_ea[i_idx][2:0];
            RSP_TSEL_O  <= i_ea[i_idx][3];
         end
         else
         begin
            RSP_PADDR_O <= pa(u_ppn[u_idx], u_sz[u_idx], REQ_VADDR_I);
            RSP_CACHE_O <= u_c_q[u_idx];
            RSP_WTHRU_O <= u_wt_q[u_idx];
            RSP_SPACE_O <= u_ea[u_idx][2:0];
            RSP_TSEL_O  <= u_ea[u_idx][3];
         end
         if (REG_RD_I)
         begin
            if (REG_ADDR_I == OFS_CTRL)
               REG_RDATA_O <= 32'(urc_q) << CTRL_URC_LSB | 32'(sv_q) << CTRL_SV_BIT | 32'(instr_replace_state_q);
            else if (REG_ADDR_I == OFS_PAGE_ENTRY_HIGH_REG) REG_RDATA_O <= page_entry_high_reg_q;
            else if (REG_ADDR_I == OFS_PAGE_ENTRY_LOW_REG) REG_RDATA_O <= page_entry_low_reg_q;
            else if (REG_ADDR_I == OFS_PAGE_ENTRY_ASSIST_REG) REG_RDATA_O <= {28'h0, page_entry_assist_reg_q};
            else if (REG_ADDR_I == OFS_STATUS) REG_RDATA_O <= {16'h0, 8'(u_v_q[uix]), 5'h0, exc_q};
            else if (REG_ADDR_I == OFS_IADDR) REG_RDATA_O <= {24'h0, iaddr_q};
            else if (REG_ADDR_I == OFS_IDATA) REG_RDATA_O <= {28'h0, i_v_q};
            else REG_RDATA_O <= 32'h0;
         end
      end
   end

   assign BUSY_O = st_q != ST_IDLE;

   load_slot_a: assert property (@(posedge CLK_I) disable iff (!rst_n)
      do_load |=> u_v_q[$past(urc_q)] == $past(page_entry_low_reg_q[PAGE_ENTRY_LOW_REG_V])) else $error("Load did not store valid.");
   miss_exc_a: assert property (@(posedge CLK_I) disable iff (!rst_n)
      (st_q == ST_REFILL && !u_any) |=> RSP_EXC_O == EXC_IMISS) else $error("Missing instruction miss.");
   refill_a: assert property (@(posedge CLK_I) disable iff (!rst_n)
      refill_now |=> i_v_q[$past(instr_replace_state_q)]) else $error("Refill slot not valid.");
   busy_a: assert property (@(posedge CLK_I) disable iff (!rst_n)
      st_q == ST_REFILL |=> st_q == ST_DONE ##1 st_q == ST_IDLE) else $error("Refill sequence broken.");
   prot_a: assert property (@(posedge CLK_I) disable iff (!rst_n)
      (REQ_VALID_I && !REQ_INSTR_I && st_q == ST_IDLE && u_any && !u_mult && REQ_USER_I && !dpr[1])
      |=> RSP_EXC_O == EXC_DPROT) else $error("User access not refused.");
   dmiss_a: assert property (@(posedge CLK_I) disable iff (!rst_n)
      (REQ_VALID_I && !REQ_INSTR_I && st_q == ST_IDLE && !u_any) |=> RSP_EXC_O == EXC_DMISS)
      else $error("Data miss not raised.");
   iprot_a: assert property (@(posedge CLK_I) disable iff (!rst_n)
      (REQ_VALID_I && REQ_INSTR_I && st_q == ST_IDLE && i_any && !i_mult && REQ_USER_I && !i_pr_q[i_idx])
      |=> RSP_EXC_O == EXC_IPROT) else $error("Instruction protect missing.");
   noload_a: assert property (@(posedge CLK_I) disable iff (!rst_n)
      (do_load && !refill_now && !do_iwr && !do_idel) |=> $stable(i_v_q)) else $error("Load touched instr buffer.");
   wt_a: assert property (@(posedge CLK_I) disable iff (!rst_n)
      (REQ_VALID_I && !REQ_INSTR_I) |=> RSP_WTHRU_O == $past(u_wt_q[u_idx])) else $error("Write mode wrong.");
   refill_c: cover property (@(posedge CLK_I) refill_now);
   load_c:   cover property (@(posedge CLK_I) do_load);
   dhit_c:   cover property (@(posedge CLK_I) RSP_VALID_O && RSP_EXC_O == EXC_NONE);

endmodule : txl_top

`default_nettype wire

// ==== verilog/txl_pkg.sv ====
package txl_pkg;

   // Register offsets on the plain register port.
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_PAGE_ENTRY_HIGH_REG   = 8'h04;
   localparam logic [7:0] OFS_PAGE_ENTRY_LOW_REG   = 8'h08;
   localparam logic [7:0] OFS_PAGE_ENTRY_ASSIST_REG   = 8'h0C;
   localparam logic [7:0] OFS_CMD    = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;
   localparam logic [7:0] OFS_IADDR  = 8'h18;
   localparam logic [7:0] OFS_IDATA  = 8'h1C;

   // Control register fields.
   localparam int CTRL_SV_BIT   = 8;
   localparam int CTRL_INSTR_REPLACE_STATE_LSB = 0;
   localparam int CTRL_URC_LSB  = 16;

   // Page entry low register fields.
   localparam int PAGE_ENTRY_LOW_REG_WT   = 0;
   localparam int PAGE_ENTRY_LOW_REG_SH   = 1;
   localparam int PAGE_ENTRY_LOW_REG_D    = 2;
   localparam int PAGE_ENTRY_LOW_REG_C    = 3;
   localparam int PAGE_ENTRY_LOW_REG_SZ0  = 4;
   localparam int PAGE_ENTRY_LOW_REG_PR   = 5;
   localparam int PAGE_ENTRY_LOW_REG_SZ1  = 7;
   localparam int PAGE_ENTRY_LOW_REG_V    = 8;
   localparam int PAGE_ENTRY_LOW_REG_PPN  = 10;

   // Command register bits.
   localparam int CMD_LOAD  = 0;
   localparam int CMD_IWR   = 1;
   localparam int CMD_IDEL  = 2;
   localparam int CMD_UDEL  = 3;

   // Page size codes.
   localparam logic [1:0] SZ_1K   = 2'h0;
   localparam logic [1:0] SZ_4K   = 2'h1;
   localparam logic [1:0] SZ_64K  = 2'h2;
   localparam logic [1:0] SZ_1M   = 2'h3;

   // Exception codes reported on the exception port.
   localparam logic [2:0] EXC_NONE  = 3'h0;
   localparam logic [2:0] EXC_IMISS = 3'h1;
   localparam logic [2:0] EXC_IPROT = 3'h2;
   localparam logic [2:0] EXC_DMISS = 3'h3;
   localparam logic [2:0] EXC_DPROT = 3'h4;
   localparam logic [2:0] EXC_DMULT = 3'h5;
   localparam logic [2:0] EXC_IMULT = 3'h6;
   localparam logic [2:0] EXC_WRITE = 3'h7;

   typedef enum logic [1:0] {ST_IDLE, ST_REFILL, ST_DONE} txl_state_t;

endpackage : txl_pkg

// ==== bench/txl_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// Core side of the translation port.
// The request fields are held until the next go, so a retry after a refill repeats the same request.
module txl_core_model (
   // Clock and reset.
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   // Request from the bench: {instr, write, user, vaddr}.
   input  wire logic        go_i,
   input  wire logic [34:0] req_i,
   input  wire logic        busy_i,
   // Request towards the translator.
   output logic             valid_o,
   output logic      [34:0] req_o
);
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         valid_o <= 1'b0;
         req_o   <= 35'h0;
      end
      else if (go_i)
      begin
         req_o   <= req_i;
         valid_o <= 1'b1;
      end
      else if (!busy_i)
         valid_o <= 1'b0;
   end
endmodule : txl_core_model

`default_nettype wire

// ==== bench/txl_top_bench.sv ====
`timescale 1ns/1ps
`default_nettype none

module txl_top_bench;
   import txl_pkg::*;
   localparam logic [28:0] PPN_A = 29'h0ABC_DC00;
   localparam logic [28:0] PPN_B = 29'h1234_5400;
   logic        clk, rst_n, pwr_on, go, wr, rd, rv, rvalid, busy, cache, wthru, tsel, got;
   logic [7:0]  addr;
   logic [31:0] wdata, rdata, v;
   logic [34:0] req, req_q;
   logic [28:0] paddr, r_pa;
   logic [2:0]  space, exc, r_exc;
   logic [5:0]  r_att;
   int          fail_count = 0;
   int          checks = 0;
   int          cyc = 0;
   int          sh[4] = '{10, 12, 16, 20};

   txl_top uut (.CLK_I(clk), .RST_N_I(rst_n), .PWR_ON_I(pwr_on), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
      .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .REQ_VALID_I(rv), .REQ_INSTR_I(req_q[34]),
      .REQ_WRITE_I(req_q[33]), .REQ_USER_I(req_q[32]), .REQ_VADDR_I(req_q[31:0]), .RSP_VALID_O(rvalid),
      .RSP_PADDR_O(paddr), .RSP_CACHE_O(cache), .RSP_WTHRU_O(wthru), .RSP_SPACE_O(space),
      .RSP_TSEL_O(tsel), .RSP_EXC_O(exc), .BUSY_O(busy));
   txl_core_model core (.clk_i(clk), .rst_n_i(rst_n), .go_i(go), .req_i(req), .busy_i(busy),
      .valid_o(rv), .req_o(req_q));

   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic give_verdict();
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : give_verdict

   // The whole run needs under a thousand cycles; a hang is cut off well beyond that.
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         fail_count++;
         give_verdict();
      end
   end

   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e)
      begin
         fail_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : cmp

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask : reg_wr

   task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1;
      d = rdata;
   endtask : reg_rd

   task automatic do_reset(input logic pw);
      @(posedge clk);
      pwr_on <= pw;
      rst_n  <= 1'b0;
      repeat (5) @(posedge clk);
      rst_n  <= 1'b1;
      repeat (4) @(posedge clk);
   endtask : do_reset

   // Bits c, d, s, w of cdsw are the cacheable, dirty, share and write-through flags.
   function automatic logic [31:0] pte(input logic [28:0] physical_page_number, input logic [1:0] sz, input logic [1:0] pr,
                                       input logic [3:0] cdsw);
      pte = {3'h0, physical_page_number[28:10], 10'h0} | (32'h1 << PAGE_ENTRY_LOW_REG_V) | (32'(sz[1]) << PAGE_ENTRY_LOW_REG_SZ1)
          | (32'(sz[0]) << PAGE_ENTRY_LOW_REG_SZ0) | (32'(pr) << PAGE_ENTRY_LOW_REG_PR) | (32'(cdsw[3]) << PAGE_ENTRY_LOW_REG_C)
          | (32'(cdsw[2]) << PAGE_ENTRY_LOW_REG_D) | (32'(cdsw[1]) << PAGE_ENTRY_LOW_REG_SH) | (32'(cdsw[0]) << PAGE_ENTRY_LOW_REG_WT);
   endfunction : pte

   function automatic logic [31:0] epa(input logic [28:0] physical_page_number, input int sz, input logic [31:0] va);
      logic [28:0] m;
      m   = (29'h1 << sh[sz]) - 29'h1;
      epa = 32'((physical_page_number & ~m) | (va[28:0] & m));
   endfunction : epa

   task automatic load(input int idx, input logic [31:0] va, input logic [31:0] page_entry_low_reg, input logic [3:0] page_entry_assist_reg);
      reg_wr(OFS_PAGE_ENTRY_HIGH_REG, {va[31:10], 2'h0, 8'h5A});
      reg_wr(OFS_PAGE_ENTRY_LOW_REG, page_entry_low_reg);
      reg_wr(OFS_PAGE_ENTRY_ASSIST_REG, {28'h0, page_entry_assist_reg});
      reg_wr(OFS_CTRL, 32'(idx) << CTRL_URC_LSB);
      reg_wr(OFS_CMD, 32'h1 << CMD_LOAD);
   endtask : load

   // Request attributes iwu are {instr, write, user}; got stays low when no answer came.
   task automatic xl(input logic [2:0] iwu, input logic [31:0] va);
      @(posedge clk);
      req <= {iwu, va};
      go  <= 1'b1;
      @(posedge clk);
      go  <= 1'b0;
      got = 1'b0;
      for (int k = 0; k < 6 && !got; k++)
      begin
         @(posedge clk);
         #1;
         if (rvalid === 1'b1)
         begin
            got   = 1'b1;
            r_exc = exc;
            r_pa  = paddr;
            r_att = {cache, wthru, tsel, space};
         end
      end
   endtask : xl

   task automatic xc(input logic [2:0] iwu, input logic [31:0] va, input logic [2:0] e);
      xl(iwu, va);
      cmp(32'(got), 32'h1);
      cmp(32'(r_exc), 32'(e));
   endtask : xc

   initial
   begin
      {rst_n, go, wr, rd, got} = 5'h0;
      pwr_on = 1'b1;
      addr   = 8'h00;
      wdata  = 32'h0;
      req    = 35'h0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      reg_wr(OFS_IADDR, 32'h0);
      reg_rd(OFS_STATUS, v);
      cmp(v, 32'h0);
      reg_rd(8'hFC, v);
      cmp(v, 32'h0);
      $display("test reset done");

      for (int s = 0; s < 4; s++)
      begin
         v = 32'h0100_0000 * (s + 1);
         load(s, v, pte(PPN_A, 2'(s), 2'h3, {3'b111, s[0]}), {s[1], 3'(2 * s + 1)});
         xc(3'b000, v + (32'h1 << sh[s]) - 32'h4, EXC_NONE);
         cmp(32'(r_pa), epa(PPN_A, s, v + (32'h1 << sh[s]) - 32'h4));
         cmp(32'(r_att), {26'h0, 1'b1, s[0], s[1], 3'(2 * s + 1)});
         xc(3'b000, v + (32'h1 << sh[s]), EXC_DMISS);
      end
      $display("test page sizes done");

      for (int p = 0; p < 4; p++)
      begin
         load(4, 32'h0600_0000, pte(PPN_A, SZ_4K, 2'(p), 4'b1110), 4'h0);
         for (int m = 0; m < 4; m++)
            xc({1'b0, 2'(m)}, 32'h0600_0010, ((m[0] && !p[1]) || (m[1] && !p[0])) ? EXC_DPROT : EXC_NONE);
      end
      load(4, 32'h0600_0000, pte(PPN_A, SZ_4K, 2'h3, 4'b1010), 4'h0);
      xc(3'b010, 32'h0600_0010, EXC_WRITE);
      xc(3'b000, 32'h0600_0010, EXC_NONE);
      $display("test protection done");

      load(63, 32'h0700_0000, pte(PPN_A, SZ_4K, 2'h3, 4'b1100), 4'h0);
      xc(3'b001, 32'h0700_0020, EXC_NONE);
      reg_wr(OFS_PAGE_ENTRY_HIGH_REG, {22'h01_C000, 2'h0, 8'h33});
      xc(3'b001, 32'h0700_0020, EXC_DMISS);
      xc(3'b000, 32'h0700_0020, EXC_DMISS);
      reg_wr(OFS_CTRL, 32'h1 << CTRL_SV_BIT);
      xc(3'b000, 32'h0700_0020, EXC_NONE);
      xc(3'b001, 32'h0700_0020, EXC_DMISS);
      reg_wr(OFS_CTRL, 32'h0);
      $display("test process tag done");

      load(6, 32'h0800_0000, pte(PPN_A, SZ_4K, 2'h2, 4'b1111), 4'h0);
      xl(3'b101, 32'h0800_0100);
      cmp(32'(got), 32'h0);
      xc(3'b101, 32'h0800_0100, EXC_NONE);
      cmp(32'(r_pa), epa(PPN_A, 1, 32'h0800_0100));
      cmp(32'(r_att), 32'h20);
      load(6, 32'h0800_0000, pte(PPN_B, SZ_4K, 2'h2, 4'b1111), 4'h0);
      xc(3'b101, 32'h0800_0100, EXC_NONE);
      cmp(32'(r_pa), epa(PPN_A, 1, 32'h0800_0100));
      xc(3'b000, 32'h0800_0100, EXC_NONE);
      cmp(32'(r_pa), epa(PPN_B, 1, 32'h0800_0100));
      xc(3'b100, 32'h0900_0000, EXC_IMISS);
      reg_rd(OFS_STATUS, v);
      cmp(32'(v[2:0]), 32'(EXC_IMISS));
      load(7, 32'h0A00_0000, pte(PPN_A, SZ_4K, 2'h1, 4'b1110), 4'h0);
      xl(3'b101, 32'h0A00_0000);
      xc(3'b101, 32'h0A00_0000, EXC_IPROT);
      reg_rd(OFS_IDATA, v);
      cmp(v, 32'h1);
      $display("test instruction done");

      do_reset(1'b0);
      reg_wr(OFS_IADDR, 32'd63);
      reg_rd(OFS_STATUS, v);
      cmp(32'(v[8]), 32'h1);
      xc(3'b000, 32'h0600_0010, EXC_NONE);
      do_reset(1'b1);
      reg_wr(OFS_IADDR, 32'd63);
      reg_rd(OFS_STATUS, v);
      cmp(32'(v[8]), 32'h0);
      $display("test resets done");
      give_verdict();
   end
endmodule : txl_top_bench

`default_nettype wire
